// [fee_emulator.sv]
module fee_emulator
  import fee_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       emulatedStoreWrite,
  input  wire logic       emulatedStoreRead,
  input  wire logic [7:0] busSpeedCode,
  input  wire logic [3:0] recordSize,
  input  wire logic [7:0] pageAddrHigh,
  input  wire logic [7:0] pageAddrLow,
  input  wire logic [7:0] ramRdData,
  output logic      [3:0] ramIndex,
  output logic            ramWe,
  output logic      [7:0] ramWrData,
  output logic            opBusy,
  output logic            opDone,
  output logic            opIgnored,
  output logic      [15:0] flashAddr,
  output logic            flashRead,
  output logic            flashProg,
  output logic            flashErase,
  output logic      [7:0] flashWrData,
  output logic      [7:0] flashTimeScale,
  input  wire logic [7:0] flashRdData,
  input  wire logic       flashReady
);
  fee_state_e state_q, state_d;
  logic       isWrite_q, isWrite_d;
  logic [3:0] size_q, size_d;
  logic [6:0] count_q, count_d;
  logic [6:0] idx_q, idx_d;
  logic [8:0] pageHi_q, pageHi_d;
  logic [7:0] spd_q, spd_d;
  logic       ignored_q, ignored_d;
  logic [3:0] ramIdx_q, ramIdx_d;
  logic       ramWe_q, ramWe_d;
  logic [7:0] ramWd_q, ramWd_d;
  logic [6:0] slotCap, slotBase, readBase;
  logic [6:0] curOfs;

  fee_slot_calc u_calc (
    .recordSize   (size_q),
    .slotCount    (count_q),
    .slotCapacity (slotCap),
    .slotBase     (slotBase)
  );

  fee_slot_calc u_last (
    .recordSize   (size_q),
    .slotCount    ((count_q == 7'h00) ? 7'h00 : count_q - 7'h01),
    .slotCapacity (),
    .slotBase     (readBase)
  );

  always_comb begin
    state_d   = state_q;
    isWrite_d = isWrite_q;
    size_d    = size_q;
    count_d   = count_q;
    idx_d     = idx_q;
    pageHi_d  = pageHi_q;
    spd_d     = spd_q;
    ignored_d = 1'b0;
    ramIdx_d  = ramIdx_q;
    ramWe_d   = 1'b0;
    ramWd_d   = ramWd_q;
    curOfs    = 7'h00;
    flashAddr = 16'h0000;
    flashRead = 1'b0;
    flashProg = 1'b0;
    flashErase = 1'b0;
    flashWrData = ramRdData;
    unique case (state_q)
      S_IDLE: begin
        if (emulatedStoreWrite || emulatedStoreRead) begin
          isWrite_d = emulatedStoreWrite;
          size_d    = recordSize;  // no range
          pageHi_d  = {pageAddrHigh, pageAddrLow[7]};
          spd_d     = busSpeedCode;
          idx_d     = RST_INDEX;
          state_d   = S_SIZE;
        end
      end
      S_SIZE: begin
        flashRead = 1'b1;
        flashAddr = {pageHi_q, CTRL_SIZE_OFS};
        if (flashReady) begin
          count_d = (flashRdData == ERASED_BYTE) ? RST_COUNT : 7'h7f;
          if (flashRdData != ERASED_BYTE &&
              flashRdData[3:0] != size_q) begin
            ignored_d = 1'b1;
            state_d   = S_DONE;
          end else begin
            state_d = S_CNT;
          end
        end
      end
      S_CNT: begin
        flashRead = 1'b1;
        flashAddr = {pageHi_q, CTRL_CNT_OFS};
        if (flashReady) begin
          // count stored as the bitwise inverse of the binary count in bits 6:0, bit 7 left at one
          count_d = (count_q == RST_COUNT) ? RST_COUNT : ~flashRdData[6:0];
          state_d = S_CHECK;
        end
      end
      S_CHECK: begin
        idx_d    = RST_INDEX;
        ramIdx_d = 4'h0;
        if (!isWrite_q) begin
          if (count_q == RST_COUNT) begin
            ignored_d = 1'b1;
            state_d   = S_DONE;
          end else begin
            state_d = S_LOAD;
          end
        end else if (count_q >= slotCap) begin
          state_d = S_ERASE;
        end else begin
          state_d = S_PROG;
        end
      end
      S_ERASE: begin
        flashErase = 1'b1;
        flashAddr  = {pageHi_q, 7'h00};  // whole page only
        if (flashReady) begin
          count_d = RST_COUNT;
          state_d = S_PROG;
        end
      end
      S_PROG: begin
        curOfs      = DATA_BASE_OFS + slotBase + idx_q;
        flashProg   = 1'b1;
        flashAddr   = {pageHi_q, curOfs};  // next blank slot
        flashWrData = ramRdData;
        ramIdx_d    = idx_q[3:0];
        if (flashReady) begin
          idx_d    = idx_q + 7'h01;
          ramIdx_d = 4'(idx_q + 7'h01);
          if (idx_q + 7'h01 == {3'h0, size_q}) begin
            idx_d   = 7'h00;
            state_d = S_CTRL;
          end
        end
      end
      S_CTRL: begin
        flashProg = 1'b1;
        if (idx_q == 7'h00) begin
          flashAddr   = {pageHi_q, CTRL_SIZE_OFS};
          flashWrData = {4'h0, size_q};
        end else begin
          flashAddr   = {pageHi_q, CTRL_CNT_OFS};
          flashWrData = {1'b1, ~(count_q + 7'h01)};
        end
        if (flashReady) begin
          idx_d = idx_q + 7'h01;
          if (idx_q != 7'h00) begin
            count_d = count_q + 7'h01;
            state_d = S_DONE;
          end
        end
      end
      S_LOAD: begin
        curOfs    = DATA_BASE_OFS + readBase + idx_q;
        flashRead = 1'b1;
        flashAddr = {pageHi_q, curOfs};
        if (flashReady) begin
          ramWe_d  = 1'b1;
          ramIdx_d = idx_q[3:0];
          ramWd_d  = flashRdData;
          idx_d    = idx_q + 7'h01;
          if (idx_q + 7'h01 == {3'h0, size_q}) state_d = S_DONE;
        end
      end
      S_DONE: begin
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q   <= S_IDLE;
      isWrite_q <= 1'b0;
      size_q    <= RST_SIZE;
      count_q   <= RST_COUNT;
      idx_q     <= RST_INDEX;
      pageHi_q  <= 9'h000;
      spd_q     <= 8'h00;
      ignored_q <= 1'b0;
      ramIdx_q  <= 4'h0;
      ramWe_q   <= 1'b0;
      ramWd_q   <= 8'h00;
    end else begin
      state_q   <= state_d;
      isWrite_q <= isWrite_d;
      size_q    <= size_d;
      count_q   <= count_d;
      idx_q     <= idx_d;
      pageHi_q  <= pageHi_d;
      spd_q     <= spd_d;
      ignored_q <= ignored_d | (ignored_q & (state_q == S_DONE));
      ramIdx_q  <= ramIdx_d;
      ramWe_q   <= ramWe_d;
      ramWd_q   <= ramWd_d;
    end
  end

  always_comb begin
    ramIndex       = ramIdx_q;
    ramWe          = ramWe_q;
    ramWrData      = ramWd_q;
    opBusy         = (state_q != S_IDLE);
    opDone         = (state_q == S_DONE);
    opIgnored      = (state_q == S_DONE) && ignored_q;
    flashTimeScale = spd_q;
  end

  a_erase_whole_page: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    flashErase |-> flashAddr[6:0] == 7'h00)
    else $error("erase not page aligned");

  a_prog_in_data: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (flashProg && state_q == S_PROG) |-> flashAddr[6:0] < 7'd120)
    else $error("record programmed into control area");

  a_ignore_no_flash: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    opIgnored |-> $past(state_q) == S_SIZE || $past(state_q) == S_CHECK)
    else $error("ignored op after flash change");

  a_ignore_no_ram: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    opIgnored |-> !ramWe && !$past(ramWe))
    else $error("ram written on ignored read");

  sequence s_full_write;
    state_q == S_CHECK && isWrite_q && count_q >= slotCap;
  endsequence
  a_full_erases: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_full_write |=> state_q == S_ERASE)
    else $error("full page not erased");

  a_append_slot: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_CHECK && isWrite_q && count_q < slotCap)
      |=> state_q == S_PROG && count_q == $past(count_q))
    else $error("write did not append");

  a_ctrl_update: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_PROG && $past(state_q) != S_PROG)
      |-> ##[1:1000] state_q == S_CTRL)
    else $error("control area not updated");

  a_read_load: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_LOAD && flashReady) |=> ramWe)
    else $error("read byte not stored");

  a_speed_scale: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_IDLE && emulatedStoreWrite)
      |=> flashTimeScale == $past(busSpeedCode))
    else $error("speed code not latched");
endmodule

// [fee_pkg.sv]
package fee_pkg;
  localparam int unsigned PAGE_BYTES     = 128;
  localparam int unsigned CTRL_BYTES     = 8;
  localparam int unsigned DATA_BYTES     = 120;
  localparam int unsigned REC_MIN        = 2;
  localparam int unsigned REC_MAX        = 15;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [6:0]  CTRL_SIZE_OFS  = 7'h78;
  localparam logic [6:0]  CTRL_CNT_OFS   = 7'h79;
  localparam logic [6:0]  DATA_BASE_OFS  = 7'h00;
  localparam logic [3:0]  RST_SIZE       = 4'h0;
  localparam logic [6:0]  RST_COUNT      = 7'h00;
  localparam logic [6:0]  RST_INDEX      = 7'h00;

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_SIZE  = 9'h002,
    S_CNT   = 9'h004,
    S_CHECK = 9'h008,
    S_ERASE = 9'h010,
    S_PROG  = 9'h020,
    S_CTRL  = 9'h040,
    S_LOAD  = 9'h080,
    S_DONE  = 9'h100
  } fee_state_e;
endpackage

// [fee_slot_calc.sv]
module fee_slot_calc
  import fee_pkg::*;
(
  input  wire logic [3:0] recordSize,
  input  wire logic [6:0] slotCount,
  output logic      [6:0] slotCapacity,
  output logic      [6:0] slotBase
);
  logic [13:0] prod;
  always_comb begin
    slotCapacity = 7'(DATA_BYTES / ((recordSize == 4'h0) ? 1 : recordSize));
    prod         = 14'(slotCount) * 14'(recordSize);
    slotBase     = prod[6:0];
  end
endmodule

// [fee_flash_model.sv]
module fee_flash_model (
  input  wire logic [15:0] flashAddr,
  input  wire logic        clk_sys,
  input  wire logic        flashRead,
  input  wire logic        flashProg,
  input  wire logic        flashErase,
  input  wire logic [7:0]  flashWrData,
  output logic      [7:0]  flashRdData,
  output logic             flashReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] lastRd;
  logic       anyOp;
  int         waitCnt;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    lastRd = 8'h00;
    waitCnt = 0;
  end
  assign anyOp = flashRead | flashProg | flashErase;
  assign flashReady = anyOp && waitCnt == 0;
  // idle data bus shows the inverse of the last byte read
  assign flashRdData = (flashRead && flashReady) ? mem[flashAddr[7:0]]
                                                 : ~lastRd;
  always @(posedge clk_sys) begin
    if (flashReady) begin
      waitCnt <= $urandom_range(3);
      if (flashRead) lastRd <= mem[flashAddr[7:0]];
      // byte program replaces contents, control bytes rewritten in place
      if (flashProg) mem[flashAddr[7:0]] <= flashWrData;
      if (flashErase) begin
        for (int i = 0; i < 128; i++) mem[{flashAddr[7], 7'(i)}] <= 8'hff;
      end
    end else if (anyOp && waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
    end
  end
endmodule

// [tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_n = 0, emulatedStoreWrite = 0, emulatedStoreRead = 0;
  logic [7:0]  busSpeedCode = 0, pageAddrHigh = 8'hef, pageAddrLow = 0;
  logic [3:0]  recordSize = 4'h2, ramIndex;
  logic [7:0]  ramRdData, ramWrData, flashWrData, flashTimeScale, flashRdData;
  logic [15:0] flashAddr;
  logic        ramWe, opBusy, opDone, opIgnored, flashReady;
  logic        flashRead, flashProg, flashErase;
  logic [7:0]  ram [16];
  logic [7:0]  expRec [2][15];
  logic [7:0]  expFirst [2];
  int          expSize [2], expCnt [2];
  int          n_errors = 0, total_checks = 0;

  always #10 clk_sys = ~clk_sys;
  assign ramRdData = ram[ramIndex];
  always @(posedge clk_sys) if (ramWe) ram[ramIndex] <= ramWrData;

  fee_emulator DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .emulatedStoreWrite(emulatedStoreWrite),
    .emulatedStoreRead(emulatedStoreRead), .busSpeedCode(busSpeedCode),
    .recordSize(recordSize), .pageAddrHigh(pageAddrHigh),
    .pageAddrLow(pageAddrLow), .ramRdData(ramRdData), .ramIndex(ramIndex),
    .ramWe(ramWe), .ramWrData(ramWrData), .opBusy(opBusy), .opDone(opDone),
    .opIgnored(opIgnored), .flashAddr(flashAddr), .flashRead(flashRead),
    .flashProg(flashProg), .flashErase(flashErase),
    .flashWrData(flashWrData), .flashTimeScale(flashTimeScale),
    .flashRdData(flashRdData), .flashReady(flashReady));
  fee_flash_model FLASH (.clk_sys(clk_sys), .flashAddr(flashAddr),
    .flashRead(flashRead), .flashProg(flashProg), .flashErase(flashErase),
    .flashWrData(flashWrData), .flashRdData(flashRdData),
    .flashReady(flashReady));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic doOp(input bit wr, input int pg, input int sz);
    logic [7:0] ramOld [16];
    logic [7:0] spd;
    bit ign;
    int n;
    int base;
    if (wr) for (int i = 0; i < sz; i++) ram[i] = 8'($urandom);
    ramOld = ram;
    spd = 8'($urandom);
    @(posedge clk_sys);
    emulatedStoreWrite <= wr;
    emulatedStoreRead <= !wr || 1'($urandom);
    recordSize <= 4'(sz);
    pageAddrLow <= pg ? 8'h80 : 8'h00;
    busSpeedCode <= spd;
    @(posedge clk_sys);
    emulatedStoreWrite <= 1'b0;
    emulatedStoreRead <= 1'b0;
    n = 0;
    @(negedge clk_sys);
    chk(opBusy, 1'b1);
    do begin
      @(negedge clk_sys);
      n++;
    end while (opDone !== 1'b1 && n < 3000);
    ign = (expSize[pg] != 0 && expSize[pg] != sz) || (!wr && expCnt[pg] == 0);
    chk(opDone, 1'b1);
    chk(opIgnored, ign);
    chk(flashTimeScale, spd);
    @(negedge clk_sys);
    chk(opBusy, 1'b0);
    if (wr && ign) chk(FLASH.mem[pg*128 + expCnt[pg]*expSize[pg]], 8'hff);
    if (wr && !ign) begin
      if (expCnt[pg] == 120 / sz) expCnt[pg] = 0;
      expSize[pg] = sz;
      base = pg*128 + expCnt[pg]*sz;
      if (expCnt[pg] == 0) expFirst[pg] = ram[0];
      for (int i = 0; i < sz; i++) begin
        expRec[pg][i] = ram[i];
        chk(FLASH.mem[base+i], ram[i]);
      end
      chk(FLASH.mem[pg*128], expFirst[pg]);
      if (expCnt[pg] == 0) chk(FLASH.mem[pg*128+sz], 8'hff);
      expCnt[pg]++;
    end
    if (!wr) begin
      for (int i = 0; i < 16; i++) begin
        chk(ram[i], (!ign && i < sz) ? expRec[pg][i] : ramOld[i]);
      end
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h881d));
    foreach (ram[i]) ram[i] = 8'h00;
    expSize = '{0, 0};
    expCnt = '{0, 0};
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    doOp(0, 0, 2);
    repeat (61) doOp(1, 0, 2);
    doOp(0, 0, 2);
    repeat (9) doOp(1, 1, 15);
    doOp(0, 1, 15);
    doOp(1, 1, 4);
    doOp(0, 1, 4);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    doOp(0, 0, 2);
    doOp(0, 1, 15);
    wrap_up();
  end
endmodule
